/* pwm_pkg.sv */
`default_nettype none

package pwm_pkg;

	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] CCP_CONTROL_OFS      = 8'h00;
	localparam logic [7:0] DUTY_LOW_OFS         = 8'h04;
	localparam logic [7:0] DUTY_HIGH_OFS        = 8'h08;
	localparam logic [7:0] TIMER_SELECT_OFS     = 8'h0c;
	localparam logic [7:0] PIN_DIRECTION_OFS    = 8'h10;
	localparam logic [7:0] PERIPHERAL_FLAG_OFS  = 8'h14;
	localparam logic [7:0] TIMER_CONTROL_OFS    = 8'h20;
	localparam logic [7:0] PERIOD_OFS           = 8'h30;
	localparam logic [7:0] TIMER_COUNT_OFS      = 8'h40;
	localparam logic [7:0] TIMER_STRIDE         = 8'h04;
	localparam int         TIMER_NUM            = 3;

	// Field positions in ccp_control.
	localparam int MODE_LSB      = 0;
	localparam int DUTY_LSB_POS  = 4;
	// Field positions in timer_control.
	localparam int PRESCALE_LSB  = 0;
	localparam int TIMER_ON_POS  = 2;
	localparam int POSTSCALE_LSB = 3;

	// Mode field values 11xx select standard PWM.
	localparam logic [1:0] PWM_MODE_TOP = 2'h3;

	// Prescale field encodings.
	localparam logic [1:0] PRESCALE_1  = 2'h0;
	localparam logic [1:0] PRESCALE_4  = 2'h1;

	// Reset values.
	localparam logic [5:0] CCP_CONTROL_RST   = 6'h00;
	localparam logic [7:0] DUTY_RST          = 8'h00;
	localparam logic [7:0] PERIOD_RST        = 8'hff;
	localparam logic [6:0] TIMER_CONTROL_RST = 7'h00;
	localparam logic [1:0] TIMER_SELECT_RST  = 2'h0;
	localparam logic       PIN_DIRECTION_RST = 1'b1;

	// One timer step lasts four system clocks.
	localparam int CLOCKS_PER_STEP = 4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic addr_mapped(input logic [7:0] a);
		logic hit;
		hit = (a == CCP_CONTROL_OFS) || (a == DUTY_LOW_OFS) ||
			(a == DUTY_HIGH_OFS) || (a == TIMER_SELECT_OFS) ||
			(a == PIN_DIRECTION_OFS) || (a == PERIPHERAL_FLAG_OFS);
		for (int i = 0; i < TIMER_NUM; i++) begin
			hit = hit ||
				(a == TIMER_CONTROL_OFS + 8'(i) * TIMER_STRIDE) ||
				(a == PERIOD_OFS + 8'(i) * TIMER_STRIDE) ||
				(a == TIMER_COUNT_OFS + 8'(i) * TIMER_STRIDE);
		end
		return hit;
	endfunction

endpackage

`default_nettype wire

/* pwm_period_timer.sv */
`default_nettype none

module pwm_period_timer (
	// Clock and reset.
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       ce_i,
	// Configuration.
	input  wire logic       timer_on_i,
	input  wire logic [1:0] prescale_i,
	input  wire logic [7:0] period_i,
	// Time base.
	output logic      [7:0] count_o,
	output logic      [1:0] low_bits_o,
	output logic            rollover_o
);

	typedef struct packed {
		logic [5:0] div;
		logic [7:0] count;
		logic       roll;
	} state_type;

	state_type state_reg;
	state_type state_next;
	logic [1:0] low_sel;
	logic       step;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		// Both quarter-phase bits and prescaler bits come from one divider.
		unique case (prescale_i)
			pwm_pkg::PRESCALE_1: begin
				low_sel = state_reg.div[1:0];
				step    = (state_reg.div[1:0] == 2'h3);
			end
			pwm_pkg::PRESCALE_4: begin
				low_sel = state_reg.div[3:2];
				step    = (state_reg.div[3:0] == 4'hf);
			end
			default: begin
				low_sel = state_reg.div[5:4];
				step    = (state_reg.div == 6'h3f);
			end
		endcase
		state_next      = state_reg;
		state_next.roll = 1'b0;
		if (timer_on_i) begin
			state_next.div = state_reg.div + 6'h01;
			if (step) begin
				if (state_reg.count == period_i) begin
					state_next.count = 8'h00;
					state_next.roll  = 1'b1;
				end else begin
					state_next.count = state_reg.count + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state_reg <= '0;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign count_o    = state_reg.count;
	assign low_bits_o = low_sel;
	assign rollover_o = state_reg.roll;

endmodule // pwm_period_timer

`default_nettype wire

/* pwm_axi_slave.sv */
`default_nettype none

module pwm_axi_slave (
	// Clock and reset.
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	// Write channels.
	input  wire logic [7:0]  awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	// Read channels.
	input  wire logic [7:0]  araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	// Register file side.
	output logic             wr_en_o,
	output logic [7:0]       wr_addr_o,
	output logic [7:0]       wr_data_o,
	input  wire logic [31:0] rd_data_i
);

	typedef struct packed {
		logic        aw_have;
		logic        w_have;
		logic [7:0]  addr;
		logic [7:0]  data;
		logic        strb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        wr_en;
	} state_type;

	state_type state_reg;
	state_type state_next;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next       = state_reg;
		state_next.wr_en = 1'b0;
		if (awvalid_i && state_reg.awready) begin
			state_next.aw_have = 1'b1;
			state_next.addr    = awaddr_i;
		end
		if (wvalid_i && state_reg.wready) begin
			state_next.w_have = 1'b1;
			state_next.data   = wdata_i[7:0];
			state_next.strb   = wstrb_i[0];
		end
		if (state_reg.aw_have && state_reg.w_have) begin
			state_next.aw_have = 1'b0;
			state_next.w_have  = 1'b0;
			state_next.bvalid  = 1'b1;
			if (pwm_pkg::addr_mapped(state_reg.addr)) begin
				state_next.bresp = pwm_pkg::RESP_OKAY;
				state_next.wr_en = state_reg.strb;
			end else begin
				state_next.bresp = pwm_pkg::RESP_SLVERR;
			end
		end
		if (state_reg.bvalid && bready_i) begin
			state_next.bvalid = 1'b0;
		end
		if (arvalid_i && state_reg.arready) begin
			state_next.rvalid = 1'b1;
			state_next.rdata  = rd_data_i;
			state_next.rresp  = pwm_pkg::addr_mapped(araddr_i) ?
				pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
		end
		if (state_reg.rvalid && rready_i) begin
			state_next.rvalid = 1'b0;
		end
		// One write in flight at a time keeps the response order trivial.
		state_next.awready = !state_next.aw_have && !state_next.bvalid &&
			!(state_reg.aw_have && state_reg.w_have);
		state_next.wready  = !state_next.w_have && !state_next.bvalid &&
			!(state_reg.aw_have && state_reg.w_have);
		state_next.arready = !state_next.rvalid;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state_reg         <= '0;
			state_reg.awready <= 1'b1;
			state_reg.wready  <= 1'b1;
			state_reg.arready <= 1'b1;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign awready_o = state_reg.awready;
	assign wready_o  = state_reg.wready;
	assign bvalid_o  = state_reg.bvalid;
	assign bresp_o   = state_reg.bresp;
	assign arready_o = state_reg.arready;
	assign rvalid_o  = state_reg.rvalid;
	assign rdata_o   = state_reg.rdata;
	assign rresp_o   = state_reg.rresp;
	assign wr_en_o   = state_reg.wr_en;
	assign wr_addr_o = state_reg.addr;
	assign wr_data_o = state_reg.data;

endmodule // pwm_axi_slave

`default_nettype wire

/* standard_pwm_generator.sv */
// Operation
// - Period lasts (period_reg+1) times 4 clocks times prescale.
// - timer_count equal to period_reg clears on the next increment.
// - Pin goes high at period start unless duty is zero.
// - Rollover copies duty_low_reg and duty_lsb_field into the buffer.
// - Duty is 10 bits: duty_low_reg high eight, duty_lsb_field low two.
// - Duty writes accepted anytime, effective after current period.
// - duty_high_buf is read-only to software while PWM is active.
// - Duty double-buffered in duty_high_buf plus a 2-bit latch.
// - Time base is timer_count plus quarter-phase or prescaler bits.
// - Time base equal to buffered duty drives the pin low.
// - Duty beyond the period leaves the pin unchanged.
// - Prescale ratios 1, 4 and 16 via timer_prescale_field.
// - Postscaler has no effect on the PWM period.
// - One of three 8-bit timers chosen by timer_select_field.
// - Resolution up to 10 bits, log2 of 4 times (period_reg+1).
// - Sleep freezes counting, state and pin; wake resumes.
// - Reset sets the pin to input and registers to reset values.
// - Waveform drives the pin only while pin_direction_bit is clear.
// - Zero ccp_control releases the pin to ordinary port use.
// - timer_period_flag sets on period end; software may wait on it.
// - Selected timer runs only while timer_on_bit is set.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`default_nettype none

module standard_pwm_generator #(
	parameter int TIMERS = pwm_pkg::TIMER_NUM
) (
	// Clock, reset and sleep freeze.
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	// AXI4-Lite write channels.
	input  wire logic [7:0]  awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	// AXI4-Lite read channels.
	input  wire logic [7:0]  araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	// Output pin.
	output logic             pwm_pin_o,
	output logic             pwm_pin_oe_o
);

	typedef struct packed {
		logic [5:0]             ccp_control;
		logic [7:0]             duty_low;
		logic [7:0]             duty_high;
		logic [1:0]             lsb_latch;
		logic [1:0]             timer_select;
		logic                   pin_direction;
		logic [TIMERS-1:0]      period_flag;
		logic [TIMERS-1:0][6:0] timer_control;
		logic [TIMERS-1:0][7:0] period;
		logic                   pin;
		logic                   pin_oe;
	} state_type;

	state_type state_reg;
	state_type state_next;

	logic                   wr_en;
	logic [7:0]             wr_addr;
	logic [7:0]             wr_data;
	logic [31:0]            rd_data;
	logic [TIMERS-1:0][7:0] t_count;
	logic [TIMERS-1:0][1:0] t_low;
	logic [TIMERS-1:0]      t_roll;
	logic [9:0]             time_base;
	logic                   sel_roll;
	logic                   pwm_active;
	logic [9:0]             next_duty;

	////////////////////////////////////////////////////////////////////////
	pwm_axi_slave u_bus (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.ce_i      (ce_i),
		.awaddr_i  (awaddr_i),
		.awvalid_i (awvalid_i),
		.awready_o (awready_o),
		.wdata_i   (wdata_i),
		.wstrb_i   (wstrb_i),
		.wvalid_i  (wvalid_i),
		.wready_o  (wready_o),
		.bresp_o   (bresp_o),
		.bvalid_o  (bvalid_o),
		.bready_i  (bready_i),
		.araddr_i  (araddr_i),
		.arvalid_i (arvalid_i),
		.arready_o (arready_o),
		.rdata_o   (rdata_o),
		.rresp_o   (rresp_o),
		.rvalid_o  (rvalid_o),
		.rready_i  (rready_i),
		.wr_en_o   (wr_en),
		.wr_addr_o (wr_addr),
		.wr_data_o (wr_data),
		.rd_data_i (rd_data)
	);

	////////////////////////////////////////////////////////////////////////
	// The postscaler bits are stored and read back only; no timer logic uses them.
	generate
		for (genvar g = 0; g < TIMERS; g++) begin : gen_timer
			pwm_period_timer u_timer (
				.ref_clk_i  (ref_clk_i),
				.nrst_i     (nrst_i),
				.ce_i       (ce_i),
				.timer_on_i (state_reg.timer_control[g]
					[pwm_pkg::TIMER_ON_POS]),
				.prescale_i (state_reg.timer_control[g]
					[pwm_pkg::PRESCALE_LSB +: 2]),
				.period_i   (state_reg.period[g]),
				.count_o    (t_count[g]),
				.low_bits_o (t_low[g]),
				.rollover_o (t_roll[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (araddr_i)
			pwm_pkg::CCP_CONTROL_OFS:
				rd_data[5:0] = state_reg.ccp_control;
			pwm_pkg::DUTY_LOW_OFS:
				rd_data[7:0] = state_reg.duty_low;
			pwm_pkg::DUTY_HIGH_OFS:
				rd_data[7:0] = state_reg.duty_high;
			pwm_pkg::TIMER_SELECT_OFS:
				rd_data[1:0] = state_reg.timer_select;
			pwm_pkg::PIN_DIRECTION_OFS:
				rd_data[0] = state_reg.pin_direction;
			pwm_pkg::PERIPHERAL_FLAG_OFS:
				rd_data[TIMERS-1:0] = state_reg.period_flag;
			default: begin
				for (int i = 0; i < TIMERS; i++) begin
					if (araddr_i == pwm_pkg::TIMER_CONTROL_OFS +
						8'(i) * pwm_pkg::TIMER_STRIDE) begin
						rd_data[6:0] = state_reg.timer_control[i];
					end
					if (araddr_i == pwm_pkg::PERIOD_OFS +
						8'(i) * pwm_pkg::TIMER_STRIDE) begin
						rd_data[7:0] = state_reg.period[i];
					end
					if (araddr_i == pwm_pkg::TIMER_COUNT_OFS +
						8'(i) * pwm_pkg::TIMER_STRIDE) begin
						rd_data[7:0] = t_count[i];
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		// Encoding 11 of the select field has no timer and runs nothing.
		if (state_reg.timer_select < 2'(TIMERS)) begin
			time_base = {t_count[state_reg.timer_select],
				t_low[state_reg.timer_select]};
			sel_roll  = t_roll[state_reg.timer_select];
		end else begin
			time_base = 10'h000;
			sel_roll  = 1'b0;
		end
		pwm_active = (state_reg.ccp_control[pwm_pkg::MODE_LSB + 2 +: 2]
			== pwm_pkg::PWM_MODE_TOP);
		next_duty  = {state_reg.duty_low, state_reg.ccp_control
			[pwm_pkg::DUTY_LSB_POS +: 2]};

		state_next = state_reg;

		// Hardware set is applied after the clear so an event wins.
		if (wr_en) begin
			unique case (wr_addr)
				pwm_pkg::CCP_CONTROL_OFS:
					state_next.ccp_control = wr_data[5:0];
				pwm_pkg::DUTY_LOW_OFS:
					state_next.duty_low = wr_data;
				pwm_pkg::DUTY_HIGH_OFS: begin
					if (!pwm_active) begin
						state_next.duty_high = wr_data;
					end
				end
				pwm_pkg::TIMER_SELECT_OFS:
					state_next.timer_select = wr_data[1:0];
				pwm_pkg::PIN_DIRECTION_OFS:
					state_next.pin_direction = wr_data[0];
				pwm_pkg::PERIPHERAL_FLAG_OFS:
					state_next.period_flag = state_reg.period_flag &
						~wr_data[TIMERS-1:0];
				default: begin
					for (int i = 0; i < TIMERS; i++) begin
						if (wr_addr == pwm_pkg::TIMER_CONTROL_OFS +
							8'(i) * pwm_pkg::TIMER_STRIDE) begin
							state_next.timer_control[i] = wr_data[6:0];
						end
						if (wr_addr == pwm_pkg::PERIOD_OFS +
							8'(i) * pwm_pkg::TIMER_STRIDE) begin
							state_next.period[i] = wr_data;
						end
					end
				end
			endcase
		end
		state_next.period_flag = state_next.period_flag | t_roll;

		if (pwm_active) begin
			if (sel_roll) begin
				// Buffer swap only at rollover keeps edges glitch free.
				state_next.duty_high = state_reg.duty_low;
				state_next.lsb_latch = state_reg.ccp_control
					[pwm_pkg::DUTY_LSB_POS +: 2];
				state_next.pin = (next_duty != 10'h000);
			end else if (time_base == {state_reg.duty_high,
				state_reg.lsb_latch}) begin
				// A duty past the period never matches, so the pin holds.
				state_next.pin = 1'b0;
			end
		end else begin
			state_next.pin = 1'b0;
		end
		state_next.pin_oe = pwm_active &&
			!state_next.pin_direction;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state_reg               <= '0;
			state_reg.ccp_control   <= pwm_pkg::CCP_CONTROL_RST;
			state_reg.duty_low      <= pwm_pkg::DUTY_RST;
			state_reg.duty_high     <= pwm_pkg::DUTY_RST;
			state_reg.timer_select  <= pwm_pkg::TIMER_SELECT_RST;
			state_reg.pin_direction <= pwm_pkg::PIN_DIRECTION_RST;
			for (int i = 0; i < TIMERS; i++) begin
				state_reg.timer_control[i] <= pwm_pkg::TIMER_CONTROL_RST;
				state_reg.period[i]        <= pwm_pkg::PERIOD_RST;
			end
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign pwm_pin_o    = state_reg.pin;
	assign pwm_pin_oe_o = state_reg.pin_oe;

endmodule // standard_pwm_generator

`default_nettype wire

/* pwm_load_model.sv */
`default_nettype none

module pwm_load_model (
	// Clock and pin.
	input  wire logic        ref_clk_i,
	input  wire logic        pin_i,
	input  wire logic        oe_i,
	// Observed waveform.
	output logic             level_o,
	output logic      [15:0] high_o,
	output logic      [15:0] period_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] high_cnt = 16'h0;
	logic [15:0] per_cnt  = 16'h0;
	logic        prev     = 1'b0;

	// The load resistor pulls the line low whenever the block lets go.
	assign level_o = oe_i ? pin_i : 1'b0;

	always_ff @(posedge ref_clk_i) begin
		prev <= level_o;
		if (level_o && !prev) begin
			period_o <= per_cnt;
			per_cnt  <= 16'h1;
			high_cnt <= 16'h1;
		end else begin
			per_cnt <= per_cnt + 16'h1;
			if (level_o) high_cnt <= high_cnt + 16'h1;
		end
		if (!level_o && prev) high_o <= high_cnt;
	end
endmodule // pwm_load_model

`default_nettype wire

/* standard_pwm_generator_checker.sv */
`default_nettype none

module standard_pwm_generator_checker (
	// Clock, reset and sleep.
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	// Bus handshakes.
	input  wire logic        awvalid_i,
	input  wire logic        awready_o,
	input  wire logic        wvalid_i,
	input  wire logic        wready_o,
	input  wire logic [1:0]  bresp_o,
	input  wire logic        bvalid_o,
	input  wire logic        bready_i,
	input  wire logic        arvalid_i,
	input  wire logic        arready_o,
	input  wire logic [31:0] rdata_o,
	input  wire logic        rvalid_o,
	input  wire logic        rready_i,
	// Output pin.
	input  wire logic        pwm_pin_o,
	input  wire logic        pwm_pin_oe_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	chk_sleep_pin_hold: assert property (
		(nrst_i && !ce_i) |=> $stable(pwm_pin_o) && $stable(pwm_pin_oe_o))
		else $error("pin moved during sleep");
	chk_sleep_bus_hold: assert property (
		(nrst_i && !ce_i) |=> $stable(bvalid_o) && $stable(rvalid_o))
		else $error("bus moved during sleep");
	chk_reset_release: assert property (
		$rose(nrst_i) |-> !pwm_pin_oe_o && !pwm_pin_o && awready_o &&
			arready_o && !bvalid_o && !rvalid_o)
		else $error("outputs not at reset state");
	chk_bresp_hold: assert property (
		(bvalid_o && !bready_i) |=> bvalid_o && $stable(bresp_o))
		else $error("write response dropped");
	chk_rdata_hold: assert property (
		(rvalid_o && !rready_i) |=> rvalid_o && $stable(rdata_o))
		else $error("read data dropped");
	chk_read_answer: assert property (
		(arvalid_i && arready_o && ce_i) |=> rvalid_o)
		else $error("read not answered");
	chk_write_answer: assert property (
		(awvalid_i && awready_o && wvalid_i && wready_o && ce_i)
			|-> ##[1:3] bvalid_o)
		else $error("write not answered");
	chk_write_busy: assert property (
		bvalid_o |-> !awready_o && !wready_o)
		else $error("write accepted while busy");

	cover property ($rose(pwm_pin_o));
	cover property (!ce_i ##1 ce_i);
	cover property (rvalid_o && !rready_i);
endmodule // standard_pwm_generator_checker

bind standard_pwm_generator standard_pwm_generator_checker
	i_standard_pwm_generator_checker (.ref_clk_i, .nrst_i, .ce_i,
	.awvalid_i, .awready_o, .wvalid_i, .wready_o, .bresp_o, .bvalid_o,
	.bready_i, .arvalid_i, .arready_o, .rdata_o, .rvalid_o, .rready_i,
	.pwm_pin_o, .pwm_pin_oe_o);

`default_nettype wire

/* standard_pwm_generator_test.sv */
`default_nettype none

module standard_pwm_generator_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] A_CCP = pwm_pkg::CCP_CONTROL_OFS;
	localparam logic [7:0] A_DTY = pwm_pkg::DUTY_LOW_OFS;
	localparam logic [7:0] A_DHI = pwm_pkg::DUTY_HIGH_OFS;
	localparam logic [7:0] A_SEL = pwm_pkg::TIMER_SELECT_OFS;
	localparam logic [7:0] A_DIR = pwm_pkg::PIN_DIRECTION_OFS;
	localparam logic [7:0] A_FLG = pwm_pkg::PERIPHERAL_FLAG_OFS;
	localparam logic [7:0] A_TC  = pwm_pkg::TIMER_CONTROL_OFS;
	localparam logic [7:0] A_PR  = pwm_pkg::PERIOD_OFS;
	localparam logic [7:0] A_CNT = pwm_pkg::TIMER_COUNT_OFS;

	logic        ref_clk_i, nrst_i, ce_i, bready_i, rready_i;
	logic        awvalid_i, wvalid_i, arvalid_i;
	logic [7:0]  awaddr_i, araddr_i;
	logic [31:0] wdata_i;
	logic [3:0]  wstrb_i;
	logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
	logic [1:0]  bresp_o, rresp_o;
	logic [31:0] rdata_o;
	logic        pwm_pin_o, pwm_pin_oe_o, level;
	logic [15:0] high_w, per_w;
	int          fail_count = 0;
	int          checked = 0;

	standard_pwm_generator i_standard_pwm_generator (.ref_clk_i, .nrst_i,
		.ce_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
		.wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i,
		.arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i,
		.pwm_pin_o, .pwm_pin_oe_o);
	pwm_load_model i_pwm_load_model (.ref_clk_i, .pin_i(pwm_pin_o),
		.oe_i(pwm_pin_oe_o), .level_o(level), .high_o(high_w),
		.period_o(per_w));

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("fail_count=%0d checked=%0d", fail_count, checked);
		if (fail_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Bready is raised only once bvalid is seen, so the hold is exercised.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr_i <= a;
		wdata_i <= d;
		awvalid_i <= 1'b1;
		wvalid_i <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (awready_o) awvalid_i <= 1'b0;
			if (wready_o) wvalid_i <= 1'b0;
		end while ((awvalid_i && !awready_o) || (wvalid_i && !wready_o));
		do @(posedge ref_clk_i); while (!bvalid_o);
		check({30'h0, bresp_o}, {30'h0, pwm_pkg::RESP_OKAY});
		bready_i <= 1'b1;
		@(posedge ref_clk_i);
		bready_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr_i <= a;
		arvalid_i <= 1'b1;
		do @(posedge ref_clk_i); while (!arready_o);
		arvalid_i <= 1'b0;
		do @(posedge ref_clk_i); while (!rvalid_o);
		rready_i <= 1'b1;
		@(posedge ref_clk_i);
		d = rdata_o;
		r = rresp_o;
		rready_i <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check(d, e);
	endtask

	task automatic count_level(input logic v, output int n);
		n = 0;
		repeat (32) begin
			@(posedge ref_clk_i);
			if (level === v) n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		rchk(A_CCP, 32'h0);
		rchk(A_PR, 32'hff);
		rchk(A_DIR, 32'h1);
		rchk(A_TC, 32'h0);
		rd(8'h18, d, r);
		check({30'h0, r}, {30'h0, pwm_pkg::RESP_SLVERR});
	endtask

	task automatic t_basic();
		logic [31:0] d;
		logic [1:0]  r;
		wr(A_DIR, 32'h1);
		wr(A_PR, 32'h3);
		wr(A_CCP, 32'h2c);
		wr(A_DTY, 32'h1);
		wr(A_SEL, 32'h0);
		wr(A_FLG, 32'h7);
		wr(A_TC, 32'h4);
		do rd(A_FLG, d, r); while (d[0] !== 1'b1);
		wr(A_DIR, 32'h0);
		// The enable is registered one edge after bvalid rises; look one edge on.
		@(posedge ref_clk_i);
		check({31'h0, pwm_pin_oe_o}, 32'h1);
		repeat (40) @(posedge ref_clk_i);
		check(32'(per_w), 32'd16);
		check(32'(high_w), 32'd6);
		rchk(A_DHI, 32'h1);
	endtask

	// Postscale bits are set to all ones to show they change nothing.
	task automatic t_prescale();
		int m;
		for (int i = 0; i < 4; i++) begin
			m = (i == 0) ? 1 : (i == 1) ? 4 : 16;
			wr(A_TC, 32'h7c | i);
			repeat (48 * m + 8) @(posedge ref_clk_i);
			check(32'(per_w), 32'(16 * m));
			check(32'(high_w), 32'(6 * m));
		end
		wr(A_TC, 32'h4);
	endtask

	task automatic t_buffer();
		wr(A_DHI, 32'h55);
		rchk(A_DHI, 32'h1);
		wr(A_DTY, 32'h2);
		wr(A_CCP, 32'h0c);
		repeat (40) @(posedge ref_clk_i);
		check(32'(high_w), 32'd8);
		rchk(A_DHI, 32'h2);
	endtask

	task automatic t_levels();
		int n;
		wr(A_DTY, 32'h0);
		repeat (40) @(posedge ref_clk_i);
		count_level(1'b1, n);
		check(32'(n), 32'h0);
		wr(A_DTY, 32'h10);
		repeat (40) @(posedge ref_clk_i);
		count_level(1'b0, n);
		check(32'(n), 32'h0);
	endtask

	task automatic t_sleep();
		logic l;
		wr(A_DTY, 32'h1);
		wr(A_CCP, 32'h2c);
		repeat (37) @(posedge ref_clk_i);
		ce_i <= 1'b0;
		@(posedge ref_clk_i);
		l = level;
		repeat (37) @(posedge ref_clk_i);
		check({31'h0, level}, {31'h0, l});
		ce_i <= 1'b1;
		repeat (40) @(posedge ref_clk_i);
		check(32'(per_w), 32'd16);
	endtask

	task automatic t_select();
		wr(A_SEL, 32'h1);
		rchk(A_CNT + 8'h04, 32'h0);
		wr(A_PR + 8'h04, 32'h1);
		wr(A_TC + 8'h04, 32'h4);
		repeat (30) @(posedge ref_clk_i);
		check(32'(per_w), 32'd8);
		check(32'(high_w), 32'd6);
	endtask

	task automatic t_release();
		wr(A_CCP, 32'h08);
		@(posedge ref_clk_i);
		check({31'h0, pwm_pin_oe_o}, 32'h0);
		wr(A_CCP, 32'h2c);
		@(posedge ref_clk_i);
		check({31'h0, pwm_pin_oe_o}, 32'h1);
		wr(A_CCP, 32'h0);
		@(posedge ref_clk_i);
		check({31'h0, pwm_pin_oe_o}, 32'h0);
		nrst_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		rchk(A_PR, 32'hff);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		nrst_i = 1'b0;
		ce_i = 1'b1;
		{awvalid_i, wvalid_i, arvalid_i, bready_i, rready_i} = 5'h0;
		awaddr_i = 8'h0;
		araddr_i = 8'h0;
		wdata_i = 32'h0;
		wstrb_i = 4'h1;
		repeat (6) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		t_reset();
		t_basic();
		t_prescale();
		t_buffer();
		t_levels();
		t_sleep();
		t_select();
		t_release();
		end_sim();
	end

	// The longest test waits about 1800 cycles; this leaves wide margin.
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		fail_count++;
		end_sim();
	end
endmodule // standard_pwm_generator_test

`default_nettype wire
